// ===== hw/fdc_drive_pin_control.sv
// Pin-level control for a floppy controller: host reset state, mode, register pick,
// head select, seek pulses, write stream and transfer end.
// Assumes the command logic drives the request inputs on mclk_i; pins are asynchronous.
`timescale 1ns/1ns
module fdc_drive_pin_control
   import fdc_pin_pkg::*;
#(
   parameter int unsigned CELL_CYC = 100                   // Cycles per write cell.
) (
   input  wire logic              mclk_i,                  // Core clock.
   input  wire logic              rst_i,                   // Asynchronous reset.
   input  wire logic              mode_select_pin_i,       // Mode strap pin.
   input  wire logic              drive_output_polarity_i, // Drive output polarity pin.
   input  wire logic              compat_reg_select_i,     // Register select pin.
   input  wire logic              chip_select_n_i,         // Chip select pin, active low.
   input  wire logic              address_bit_zero_i,      // Address bit zero pin.
   input  wire logic              transfer_end_count_i,    // Terminal count pin.
   input  wire logic              track_zero_in_i,         // Track-zero pin from drive.
   input  wire logic              xfer_start_i,            // Start a transfer, pulse.
   input  wire logic              int_req_i,               // Interrupt request from core.
   input  wire logic              dma_req_i,               // DMA request from core.
   input  wire logic [DATA_W-1:0] host_rdata_i,            // Data to drive on the host bus.
   input  wire logic              host_read_i,             // Host read cycle in progress.
   input  wire logic              head_i,                  // Logical head to select.
   input  wire logic              step_req_i,              // One seek step, pulse.
   input  wire logic              wr_req_i,                // Write data to the drive.
   input  wire logic              wr_bit_i,                // Next data bit of the stream.
   output logic                   int_req_o,               // Host interrupt request.
   output logic                   dma_request_out_o,       // Host DMA request.
   output logic [DATA_W-1:0]      host_data_o,             // Host data bus out.
   output logic                   host_data_oe_o,          // Host data bus drive enable.
   output logic                   ext_mode_o,              // High in external mode.
   output logic [1:0]             reg_pick_o,              // Compatibility register picked.
   output logic                   side_o,                  // Side select pin.
   output logic                   step_o,                  // Step pin.
   output logic                   wdata_o,                 // Write stream pin.
   output logic                   wr_enable_o,             // Write enable pin.
   output logic                   xfer_active_o,           // Transfer in progress.
   output logic                   track_zero_o,            // Synchronised track-zero.
   output logic                   bit_taken_o              // Data bit consumed, pulse.
);
   // Cell counters need at least two cycles so a cell has a visible edge.
   if (CELL_CYC < 2) begin : g_cell_check
      $error("CELL_CYC must be at least 2");
   end
   // Both counters share one width, so it must hold the longest load of either of them.
   localparam int unsigned CW = $clog2(CELL_CYC + STEP_PULSE_CYC + STEP_GAP_CYC + 1);

   // Pin synchronisers, first and second stage; only stage two is read by logic.
   logic [6:0] meta_ff, sync_ff;
   logic       mode_s, pol_s, compat_reg_select_s, cs_n_s, a0_s, tc_s, trk_s;
   assign {mode_s, pol_s, compat_reg_select_s, cs_n_s, a0_s, tc_s, trk_s} = sync_ff;

   // Registered state.
   logic              int_ff, dma_ff, oe_ff, side_ff, step_ff, wd_ff, we_ff;
   logic              act_ff, trk_ff, taken_ff, strap_ff, ext_ff;
   logic [DATA_W-1:0] dat_ff;
   op_mode_t          mode_ff;
   logic [1:0]        pick_ff;
   wr_state_t         wst_ff;
   logic [CW-1:0]     scnt_ff, wcnt_ff;
   logic              bit_ff;
   // Next values.
   logic              nxt_int, nxt_dma, nxt_oe, nxt_side, nxt_step, nxt_wd, nxt_we;
   logic              nxt_act, nxt_taken, nxt_strap, nxt_bit, nxt_ext;
   logic [DATA_W-1:0] nxt_dat;
   op_mode_t          nxt_mode;
   logic [1:0]        nxt_pick;
   wr_state_t         nxt_wst;
   logic [CW-1:0]     nxt_scnt, nxt_wcnt;

   // Next-state logic for all pin outputs.
   always_comb begin
      nxt_strap = 1'b1;
      // The mode is caught once, on the first edge after reset release.
      nxt_mode  = mode_ff;
      if (!strap_ff) begin
         nxt_mode = (mode_s == MODE_EXTERNAL) ? MODE_EXT : MODE_COMPAT;
      end
      // The mode flag is registered so that the output leaves a flip-flop.
      nxt_ext = (nxt_mode == MODE_EXT);
      // Register pick; the select pin only counts in compatibility mode.
      nxt_pick = SEL_NONE;
      if (mode_ff == MODE_COMPAT && !cs_n_s) begin
         if (!a0_s) begin
            nxt_pick = SEL_NONE;
         end else if (compat_reg_select_s) begin
            nxt_pick = SEL_CONTROL;
         end else begin
            nxt_pick = SEL_DIG_OUT;
         end
      end
      // Transfer runs from start until terminal count; the count wins a tie.
      nxt_act = act_ff;
      if (tc_s) begin
         nxt_act = 1'b0;
      end else if (xfer_start_i) begin
         nxt_act = 1'b1;
      end
      nxt_int = int_req_i;
      nxt_dma = dma_req_i & nxt_act;
      nxt_oe  = host_read_i & !cs_n_s;
      nxt_dat = host_rdata_i;
      // Side pin: active-high polarity passes the head, active-low inverts it.
      nxt_side = (pol_s == POL_ACT_HIGH) ? head_i : !head_i;
      // Step pulse: a request starts a pulse, then a gap holds off the next.
      nxt_step = step_ff;
      nxt_scnt = scnt_ff;
      if (scnt_ff != '0) begin
         nxt_scnt = scnt_ff - 1'b1;
         if (scnt_ff == CW'(STEP_GAP_CYC + 1)) begin
            nxt_step = pol_s;
         end
      end else if (step_req_i) begin
         nxt_step = !pol_s;
         nxt_scnt = CW'(STEP_PULSE_CYC + STEP_GAP_CYC);
      end else begin
         // Idle: the pin rests at the inactive level that the polarity pin names.
         nxt_step = pol_s;
      end
      // Write stream: each bit cell is a clock cell then a data cell.
      nxt_wst   = wst_ff;
      nxt_wcnt  = wcnt_ff;
      nxt_wd    = wd_ff;
      nxt_bit   = bit_ff;
      nxt_taken = 1'b0;
      nxt_we    = pol_s;
      if (wcnt_ff != '0) begin
         nxt_wcnt = wcnt_ff - 1'b1;
      end
      case (wst_ff)
         WR_IDLE: begin
            nxt_wd = 1'b0;
            if (wr_req_i) begin
               nxt_wst   = WR_CLK;
               nxt_wcnt  = CW'(CELL_CYC - 1);
               nxt_wd    = 1'b1;
               nxt_bit   = wr_bit_i;
               nxt_taken = 1'b1;
            end
         end
         WR_CLK: begin
            if (wcnt_ff == '0) begin
               nxt_wst  = WR_DATA;
               nxt_wcnt = CW'(CELL_CYC - 1);
               nxt_wd   = bit_ff;
            end
         end
         default: begin
            if (wcnt_ff == '0) begin
               nxt_wst = wr_req_i ? WR_CLK : WR_IDLE;
               nxt_wd  = wr_req_i;
               if (wr_req_i) begin
                  nxt_wcnt  = CW'(CELL_CYC - 1);
                  nxt_bit   = wr_bit_i;
                  nxt_taken = 1'b1;
               end
            end
         end
      endcase
      if (nxt_wst != WR_IDLE) begin
         nxt_we = !pol_s;
      end
   end

   // Pin synchronisers run free through reset, so the mode strap and the polarity
   // pin are already settled at the first edge after release.
   always_ff @(posedge mclk_i) begin
      meta_ff <= {mode_select_pin_i, drive_output_polarity_i, compat_reg_select_i,
                  chip_select_n_i, address_bit_zero_i, transfer_end_count_i,
                  track_zero_in_i};
      sync_ff <= meta_ff;
   end

   // Registers. Drive pins reset low; the first clocked edge applies the polarity.
   // A pin level cannot be loaded under asynchronous reset, so the high resting level
   // for polarity 1 appears from the first edge after release.
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ext_ff   <= 1'b1;
         int_ff   <= 1'b0;
         dma_ff   <= 1'b0;
         oe_ff    <= 1'b0;
         dat_ff   <= '0;
         strap_ff <= 1'b0;
         mode_ff  <= MODE_EXT;
         pick_ff  <= SEL_NONE;
         act_ff   <= 1'b0;
         side_ff  <= 1'b0;
         step_ff  <= 1'b0;
         we_ff    <= 1'b0;
         wd_ff    <= 1'b0;
         scnt_ff  <= '0;
         wcnt_ff  <= '0;
         wst_ff   <= WR_IDLE;
         bit_ff   <= 1'b0;
         taken_ff <= 1'b0;
         trk_ff   <= 1'b0;
      end else begin
         ext_ff   <= nxt_ext;
         int_ff   <= nxt_int;
         dma_ff   <= nxt_dma;
         oe_ff    <= nxt_oe;
         dat_ff   <= nxt_dat;
         strap_ff <= nxt_strap;
         mode_ff  <= nxt_mode;
         pick_ff  <= nxt_pick;
         act_ff   <= nxt_act;
         side_ff  <= nxt_side;
         step_ff  <= nxt_step;
         we_ff    <= nxt_we;
         wd_ff    <= nxt_wd;
         scnt_ff  <= nxt_scnt;
         wcnt_ff  <= nxt_wcnt;
         wst_ff   <= nxt_wst;
         bit_ff   <= nxt_bit;
         taken_ff <= nxt_taken;
         trk_ff   <= trk_s;
      end
   end

   assign int_req_o         = int_ff;
   assign dma_request_out_o = dma_ff;
   assign host_data_o       = dat_ff;
   assign host_data_oe_o    = oe_ff;
   assign ext_mode_o        = ext_ff;
   assign reg_pick_o        = pick_ff;
   assign side_o            = side_ff;
   assign step_o            = step_ff;
   assign wdata_o           = wd_ff;
   assign wr_enable_o       = we_ff;
   assign xfer_active_o     = act_ff;
   assign track_zero_o      = trk_ff;
   assign bit_taken_o       = taken_ff;

   // Assertions.
   reset_bus_idle_a: assert property (@(posedge mclk_i) $rose(strap_ff) |->
      $past(!int_ff && !dma_ff && !oe_ff))
      else $error("host outputs not idle at reset");
   ext_mode_entry_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (!strap_ff && mode_s == MODE_EXTERNAL) |=> ext_mode_o)
      else $error("external mode not entered");
   compat_pick_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (mode_ff == MODE_COMPAT && !cs_n_s && a0_s && compat_reg_select_s) |=> reg_pick_o == SEL_CONTROL)
      else $error("control register not picked");
   select_ignored_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (mode_ff == MODE_EXT) |=> reg_pick_o == SEL_NONE)
      else $error("select pin used in external mode");
   side_polarity_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      strap_ff |=> side_o == ($past(head_i) ^ $past(pol_s)))
      else $error("side pin polarity wrong");
   sequence step_start_s;
      scnt_ff == '0 && step_req_i && !pol_s;
   endsequence
   step_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      step_start_s ##1 !pol_s |-> step_o)
      else $error("step pulse missing");
   tc_ends_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      tc_s |=> !xfer_active_o ##1 !dma_request_out_o)
      else $error("transfer not ended by count");
   track_follow_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      strap_ff |-> ##3 (track_zero_o == $past(track_zero_in_i, 3)))
      else $error("track zero not followed");
   clock_cell_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (wst_ff == WR_IDLE && wr_req_i) |=> wdata_o)
      else $error("clock cell missing");
   write_en_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (wst_ff != WR_IDLE && !pol_s && $past(!pol_s)) |-> wr_enable_o)
      else $error("write enable missing");
endmodule // fdc_drive_pin_control

// ===== hw/fdc_pin_pkg.sv
// Package for the floppy controller pin block: widths, encodings and timing counts.
// Assumes a 100 MHz core clock and that all pins are sampled through two flip-flops.
package fdc_pin_pkg;
   localparam int unsigned CLK_PERIOD_NS  = 10;             // Core clock period.
   localparam int unsigned STEP_PULSE_NS  = 1000;           // Width of one seek pulse.
   localparam int unsigned STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STEP_GAP_NS    = 2000;           // Least gap between seek pulses.
   localparam int unsigned STEP_GAP_CYC   = (STEP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DATA_W         = 8;              // Host data bus width.
   localparam logic        MODE_EXTERNAL  = 1'b0;           // Mode pin level for external mode.
   localparam logic        POL_ACT_HIGH   = 1'b0;           // Polarity pin level, active high.
   localparam logic [1:0]  SEL_NONE       = 2'h0;           // No compatibility register picked.
   localparam logic [1:0]  SEL_DIG_OUT    = 2'h1;           // Digital-output register picked.
   localparam logic [1:0]  SEL_CONTROL    = 2'h2;           // Control register picked.
   localparam logic        HEAD_ZERO      = 1'b0;           // Logical head number 0.
   // Operating modes entered after reset.
   typedef enum logic {MODE_EXT, MODE_COMPAT} op_mode_t;
   // Write stream states: clock cell then data cell.
   typedef enum logic [1:0] {WR_IDLE, WR_CLK, WR_DATA} wr_state_t;
endpackage

// ===== verification/fdc_drive_model.sv
// Floppy drive stand-in that follows the head cylinder from the seek pulses.
// Assumes the bench sets the seek direction and shares the bench reset.
`timescale 1ns/1ns
module fdc_drive_model (
   input  wire logic rst_i,        // Bench reset, parks the head at home.
   input  wire logic step_i,       // Step pin from the controller.
   input  wire logic polarity_i,   // Drive output polarity pin.
   input  wire logic dir_in_i,     // High moves the head one cylinder inward.
   output logic      track_zero_o  // Track-zero pin back to the controller.
);
   int unsigned cyl_ff;            // Cylinder under the head.
   // Move at the leading edge of each active pulse; a polarity flip under reset is ignored.
   always @(posedge rst_i or posedge (step_i ^ polarity_i)) begin
      if (rst_i) begin
         cyl_ff <= 0;
      end else if (dir_in_i) begin
         cyl_ff <= cyl_ff + 1;
      end else if (cyl_ff != 0) begin
         cyl_ff <= cyl_ff - 1;
      end
   end
   // The pin is high only while the head sits over cylinder 0.
   assign track_zero_o = (cyl_ff == 0);
endmodule // fdc_drive_model

// ===== verification/test_fdc_drive_pin_control.sv
// Self-checking bench for the floppy pin block, with a drive model on the far side.
// Assumes the package constants and short write cells set by CELLS.
`timescale 1ns/1ns
module test_fdc_drive_pin_control;
   import fdc_pin_pkg::*;
   localparam int unsigned CELLS = 4; // Short cells keep the run brief.
   logic              mclk_i, rst_i, mode_select_pin_i, drive_output_polarity_i;
   logic              compat_reg_select_i, chip_select_n_i, address_bit_zero_i;
   logic              transfer_end_count_i, track_zero_in_i, xfer_start_i, int_req_i;
   logic              dma_req_i, host_read_i, head_i, step_req_i, wr_req_i, wr_bit_i;
   logic [DATA_W-1:0] host_rdata_i, host_data_o;
   logic              int_req_o, dma_request_out_o, host_data_oe_o, ext_mode_o;
   logic [1:0]        reg_pick_o;
   logic              side_o, step_o, wdata_o, wr_enable_o, xfer_active_o;
   logic              track_zero_o, bit_taken_o, dir_in;
   logic [31:0]       rnd = 32'h04db; // Xorshift state, fixed seed.
   logic [3:0]        bits;           // Data bits of one write.
   logic              wq[$];          // Write stream seen while enabled.
   int                failures = 0;
   int                compares = 0;
   fdc_drive_pin_control #(.CELL_CYC(CELLS)) u_fdc_drive_pin_control (.mclk_i, .rst_i,
      .mode_select_pin_i, .drive_output_polarity_i, .compat_reg_select_i, .chip_select_n_i,
      .address_bit_zero_i, .transfer_end_count_i, .track_zero_in_i, .xfer_start_i, .int_req_i,
      .dma_req_i, .host_rdata_i, .host_read_i, .head_i, .step_req_i, .wr_req_i, .wr_bit_i,
      .int_req_o, .dma_request_out_o, .host_data_o, .host_data_oe_o, .ext_mode_o, .reg_pick_o,
      .side_o, .step_o, .wdata_o, .wr_enable_o, .xfer_active_o, .track_zero_o, .bit_taken_o);
   fdc_drive_model u_fdc_drive_model (.rst_i, .step_i(step_o), .polarity_i(drive_output_polarity_i),
      .dir_in_i(dir_in), .track_zero_o(track_zero_in_i));
   // Free-running clock, 10 ns period.
   always #5 mclk_i = ~mclk_i;
   // Record the write stream on every cycle where write enable is active.
   always @(negedge mclk_i) if (wr_enable_o === !drive_output_polarity_i) wq.push_back(wdata_o);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // Expected register pick; outside compat mode the select pin has no say.
   function automatic logic [1:0] pick(input logic m, cs_n, a0, rs);
      if (m == MODE_EXTERNAL || cs_n || !a0) return SEL_NONE;
      return rs ? SEL_CONTROL : SEL_DIG_OUT;
   endfunction
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask
   task automatic end_of_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Reset with busy host requests, so quiet outputs prove the reset state.
   task automatic do_reset(input logic m, input logic p);
      {mode_select_pin_i, drive_output_polarity_i} = {m, p};
      {int_req_i, dma_req_i, host_read_i, chip_select_n_i, rst_i} = 5'h1d;
      cyc(10);
      chk("int_rst", int_req_o, 1'b0);
      chk("dma_rst", dma_request_out_o, 1'b0);
      chk("oe_rst", host_data_oe_o, 1'b0);
      {int_req_i, dma_req_i, host_read_i, chip_select_n_i, head_i, rst_i} = 6'h04;
      cyc(4);
      chk("ext_mode", ext_mode_o, m == MODE_EXTERNAL);
      chk("step_rst", step_o, p);
      chk("we_rst", wr_enable_o, p);
      chk("side_rst", side_o, p);
   endtask
   // Walk all select combinations, then random ones, with head and bus pins alongside.
   task automatic pins_pass();
      for (int i = 0; i < 16; i++) begin
         rnd = xs(rnd);
         {compat_reg_select_i, address_bit_zero_i, chip_select_n_i} = i < 8 ? 3'(i) : rnd[2:0];
         {head_i, int_req_i, host_read_i, host_rdata_i} = rnd[18:8];
         cyc(4);
         chk("reg_pick", reg_pick_o, pick(mode_select_pin_i, chip_select_n_i,
             address_bit_zero_i, compat_reg_select_i));
         chk("side", side_o, head_i ^ drive_output_polarity_i);
         chk("int", int_req_o, int_req_i);
         chk("oe", host_data_oe_o, host_read_i & !chip_select_n_i);
         chk("data", host_data_o, host_rdata_i);
      end
   endtask
   // One seek pulse in the given direction; its active width is measured.
   task automatic one_step(input logic d);
      int n;
      n = 0;
      dir_in = d;
      pulse(step_req_i);
      repeat (4) if (step_o !== !drive_output_polarity_i) cyc(1);
      while (step_o === !drive_output_polarity_i && n < 1000) begin
         n++;
         cyc(1);
      end
      chk("step_len", 8'(n), 8'(STEP_PULSE_CYC));
   endtask
   initial begin
      {mclk_i, rst_i, compat_reg_select_i, address_bit_zero_i, transfer_end_count_i} = '0;
      {xfer_start_i, host_rdata_i, head_i, step_req_i, wr_req_i, wr_bit_i, dir_in} = '0;
      do_reset(1'b0, 1'b0);
      pins_pass();
      chk("track_zero_in_home", track_zero_o, 1'b1);
      one_step(1'b1);
      pulse(step_req_i);
      cyc(50);
      chk("step_ignored", step_o, 1'b0);
      cyc(STEP_GAP_CYC);
      chk("track_zero_in_out", track_zero_o, 1'b0);
      one_step(1'b0);
      cyc(STEP_GAP_CYC);
      chk("track_zero_in_back", track_zero_o, 1'b1);
      dma_req_i = 1'b1;
      pulse(xfer_start_i);
      cyc(3);
      chk("active", xfer_active_o, 1'b1);
      chk("dma", dma_request_out_o, 1'b1);
      transfer_end_count_i = 1'b1;
      cyc(5);
      chk("tc_end", xfer_active_o | dma_request_out_o, 1'b0);
      pulse(xfer_start_i);
      cyc(3);
      chk("tc_wins", xfer_active_o, 1'b0);
      {transfer_end_count_i, dma_req_i} = 2'h0;
      // Four back-to-back bits; the next bit is offered once the previous is taken.
      rnd = xs(rnd);
      bits = rnd[3:0];
      wq.delete();
      wr_req_i = 1'b1;
      for (int b = 0; b < 4; b++) begin
         wr_bit_i = bits[b];
         repeat (40) if (bit_taken_o !== 1'b1) cyc(1);
         chk("taken", bit_taken_o, 1'b1);
         cyc(1);
      end
      wr_req_i = 1'b0;
      cyc(6 * CELLS);
      while (wq.size() > 0 && wq[0] !== 1'b1) void'(wq.pop_front());
      chk("wr_len", wq.size() >= 32, 1'b1);
      for (int j = 0; j < 32 && j < wq.size(); j++)
         chk("wdata", wq[j], (j % 8) < CELLS ? 1'b1 : bits[j / 8]);
      chk("we_idle", wr_enable_o, 1'b0);
      chk("wdata_idle", wdata_o, 1'b0);
      do_reset(1'b1, 1'b1);
      pins_pass();
      one_step(1'b1);
      end_of_test();
   end
   // Watchdog well beyond the expected run length.
   initial begin
      #100000;
      failures++;
      end_of_test();
   end
endmodule // test_fdc_drive_pin_control
